// [core/ptm_top.v]
// Periodic timer with compare, timer, PWM and single pulse modes behind AXI4-Lite
`include "ptm_defs.vh"

// Function
// - Mode 11 is timer mode: behaves as compare mode with same flags.
// - Timer mode leaves the output pin undriven.
// - Mode 10 is PWM, or single pulse with action 11; clear source bit is ignored.
// - PWM: period match clears counter; compare A sets duty.
// - Period value 1..1023 gives that many counts; zero gives 1024.
// - Compare A at or above period gives 100% active output.
// - PWM raises separate A and P match flags.
// - Level bit picks polarity; action field enables PWM or forces pin.
// - Invert bit inverts the waveform driven onto the pin.
// - Counter and compares keep running while the pin is forced.
// - Single pulse: run bit rising starts counter and pulse.
// - Single pulse: external trigger edge sets the run bit.
// - Pulse ends on run cleared or A match; A match clears run.
// - Single pulse: A match raises the A flag.
// - Single pulse: counter zeroed only when run rises.
// - Single pulse ignores period value and clear source bit.
// - Compare modes: clear on A (A flag only) or on P/overflow.
// - Compare A zero: counter overflows at 3FF, no A flag.
// - Compare mode: pin changes on A match per action; level bit initial.
// - PWM and pulse: level bit 0 active low, 1 active high.
module ptm_top #(
	parameter PSC_W = 2,
	parameter CNT_W = 10
) (
	// Clock and reset
	input wire CLK,
	input wire RST_N,
	// AXI4-Lite write address
	input wire [4:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	// AXI4-Lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// AXI4-Lite read address
	input wire [4:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	// AXI4-Lite read data
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// Timer pins
	input wire EXTERNAL_TRIGGER_PIN,
	output reg TIMER_PIN_O,
	output reg TIMER_PIN_OE_N
);

	// ****************************************
	// Register bus
	// ****************************************
	reg [4:0] aw_addr_r;
	reg aw_held_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg w_held_r;
	reg [`PTM_CTRL_W-1:0] ctrl_r;
	reg [CNT_W-1:0] cmpa_r;
	reg [CNT_W-1:0] cmpp_r;
	reg [CNT_W-1:0] cnt_r;
	reg [1:0] flag_r;
	reg run_prev_r;
	reg trig_prev_r;
	reg [PSC_W+1:0] psc_r;

	wire do_wr = aw_held_r & w_held_r & ~S_AXI_BVALID;
	wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	wire wr_ctrl = do_wr & (aw_addr_r[4:2] == 3'h0);
	wire wr_cmpa = do_wr & (aw_addr_r[4:2] == 3'h1);
	wire wr_cmpp = do_wr & (aw_addr_r[4:2] == 3'h2);
	wire wr_flag = do_wr & (aw_addr_r[4:2] == 3'h4);
	wire wr_ok = wr_ctrl | wr_cmpa | wr_cmpp | wr_flag | (do_wr & (aw_addr_r[4:2] == 3'h3));

	assign S_AXI_AWREADY = ~aw_held_r & ~S_AXI_BVALID;
	assign S_AXI_WREADY = ~w_held_r & ~S_AXI_BVALID;
	assign S_AXI_ARREADY = ~S_AXI_RVALID;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	wire [31:0] ctrl_wv = merge({21'h0, ctrl_r}, w_data_r, wmask);
	wire [31:0] cmpa_wv = merge({22'h0, cmpa_r}, w_data_r, wmask);
	wire [31:0] cmpp_wv = merge({22'h0, cmpp_r}, w_data_r, wmask);
	wire [1:0] flag_clr = wr_flag ? (w_data_r[1:0] & {2{w_strb_r[0]}}) : 2'h0;

	// ****************************************
	// Control fields
	// ****************************************
	wire run = ctrl_r[`PTM_F_RUN];
	wire [1:0] cks = ctrl_r[`PTM_F_CKS_HI:`PTM_F_CKS_LO];
	wire [1:0] mode = ctrl_r[`PTM_F_MODE_HI:`PTM_F_MODE_LO];
	wire [1:0] act = ctrl_r[`PTM_F_ACT_HI:`PTM_F_ACT_LO];
	wire olvl = ctrl_r[`PTM_F_OLVL];
	wire inv = ctrl_r[`PTM_F_INV];
	wire cclr = ctrl_r[`PTM_F_CCLR];

	wire is_pwm = (mode == `PTM_MODE_PWM) & (act != `PTM_ACT_TGL);
	wire is_sp = (mode == `PTM_MODE_PWM) & (act == `PTM_ACT_TGL);
	wire is_tmr = (mode == `PTM_MODE_TMR);
	wire is_cmp = ~mode[1] | is_tmr;

	// ****************************************
	// Prescaler and counter
	// ****************************************
	// Selects clock, /2, /4 or /8; the divider always runs so ticks stay even
	wire [PSC_W+1:0] psc_mask = ~({(PSC_W+2){1'b1}} << cks);
	wire tick = ((psc_r & psc_mask) == psc_mask);
	wire run_rise = run & ~run_prev_r;
	wire trig_edge = EXTERNAL_TRIGGER_PIN & ~trig_prev_r;

	wire [CNT_W-1:0] cnt_inc = cnt_r + 1'b1;
	wire adv = run & tick & ~run_rise;
	// Compare A never matches at zero, so the counter just wraps past 3FF
	wire a_hit = adv & (cmpa_r != {CNT_W{1'b0}}) & (cnt_inc == cmpa_r);
	// Period zero matches on wrap, which gives the 1024-count period
	wire p_hit = adv & (cnt_inc == cmpp_r);

	reg [CNT_W-1:0] cnt_nxt;
	reg [1:0] flag_set;
	reg run_hw_clr;

	always @* begin
		cnt_nxt = cnt_r;
		flag_set = 2'h0;
		run_hw_clr = 1'b0;
		if (is_sp) begin
			if (run_rise) begin
				cnt_nxt = {CNT_W{1'b0}};
			end else if (adv) begin
				cnt_nxt = cnt_inc;
				if (a_hit) begin
					flag_set[`PTM_F_FLAG_A] = 1'b1;
					run_hw_clr = 1'b1;
				end
			end
		end else if (is_pwm) begin
			if (adv) begin
				cnt_nxt = p_hit ? {CNT_W{1'b0}} : cnt_inc;
				flag_set[`PTM_F_FLAG_A] = a_hit;
				flag_set[`PTM_F_FLAG_P] = p_hit;
			end
		end else if (adv) begin
			cnt_nxt = cnt_inc;
			if (cclr) begin
				flag_set[`PTM_F_FLAG_A] = a_hit;
				if (a_hit) begin
					cnt_nxt = {CNT_W{1'b0}};
				end
			end else begin
				flag_set[`PTM_F_FLAG_A] = a_hit;
				flag_set[`PTM_F_FLAG_P] = p_hit;
				if (p_hit) begin
					cnt_nxt = {CNT_W{1'b0}};
				end
			end
		end
	end

	// ****************************************
	// Output pin
	// ****************************************
	// Counter below compare A means active; A at or above period keeps it active
	wire pwm_act = (cnt_r < cmpa_r);
	wire lvl_act = olvl;
	reg pin_nxt;
	reg cmp_out_r;
	reg cmp_out_nxt;
	reg run_nxt_v;

	always @* begin
		cmp_out_nxt = cmp_out_r;
		if (run_rise) begin
			cmp_out_nxt = olvl;
		end else if (a_hit & is_cmp) begin
			case (act)
				`PTM_ACT_LOW: cmp_out_nxt = 1'b0;
				`PTM_ACT_HIGH: cmp_out_nxt = 1'b1;
				`PTM_ACT_TGL: cmp_out_nxt = ~cmp_out_r;
				default: cmp_out_nxt = cmp_out_r;
			endcase
		end
	end

	always @* begin
		if (is_sp) begin
			pin_nxt = (run_nxt_v ? lvl_act : ~lvl_act) ^ inv;
		end else if (is_pwm) begin
			case (act)
				`PTM_ACT_NONE: pin_nxt = 1'b0 ^ inv;
				`PTM_ACT_LOW: pin_nxt = 1'b1 ^ inv;
				default: pin_nxt = (pwm_act ? lvl_act : ~lvl_act) ^ inv;
			endcase
		end else begin
			pin_nxt = cmp_out_nxt ^ inv;
		end
	end

	// ****************************************
	// Run bit: software write, trigger set, match clear
	// ****************************************
	always @* begin
		run_nxt_v = wr_ctrl ? ctrl_wv[`PTM_F_RUN] : run;
		if (is_sp & trig_edge) begin
			run_nxt_v = 1'b1;
		end
		// A match ends the pulse even against a racing software write
		if (run_hw_clr) begin
			run_nxt_v = 1'b0;
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_r <= `PTM_CTRL_RST;
			cmpa_r <= {CNT_W{1'b0}};
			cmpp_r <= {CNT_W{1'b0}};
			cnt_r <= {CNT_W{1'b0}};
			flag_r <= 2'h0;
			run_prev_r <= 1'b0;
			trig_prev_r <= 1'b0;
			psc_r <= {(PSC_W+2){1'b0}};
			cmp_out_r <= 1'b0;
			TIMER_PIN_O <= 1'b0;
			TIMER_PIN_OE_N <= 1'b1;
		end else begin
			if (wr_ctrl) begin
				ctrl_r[`PTM_CTRL_W-1:1] <= ctrl_wv[`PTM_CTRL_W-1:1];
			end
			ctrl_r[`PTM_F_RUN] <= run_nxt_v;
			if (wr_cmpa) begin
				cmpa_r <= cmpa_wv[CNT_W-1:0];
			end
			if (wr_cmpp) begin
				cmpp_r <= cmpp_wv[CNT_W-1:0];
			end
			cnt_r <= cnt_nxt;
			// A new event beats a clear in the same cycle
			flag_r <= (flag_r & ~flag_clr) | flag_set;
			run_prev_r <= run;
			trig_prev_r <= EXTERNAL_TRIGGER_PIN;
			psc_r <= psc_r + 1'b1;
			cmp_out_r <= cmp_out_nxt;
			TIMER_PIN_O <= pin_nxt;
			TIMER_PIN_OE_N <= is_tmr;
		end
	end

	// ****************************************
	// Bus handshakes
	// ****************************************
	always @(posedge CLK) begin
		if (!RST_N) begin
			aw_addr_r <= 5'h00;
			aw_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			w_held_r <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `PTM_RESP_OKAY;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP <= `PTM_RESP_OKAY;
			S_AXI_RDATA <= 32'h00000000;
		end else begin
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_addr_r <= S_AXI_AWADDR;
				aw_held_r <= 1'b1;
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
				w_held_r <= 1'b1;
			end
			if (do_wr) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			if (S_AXI_ARVALID & S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= `PTM_RESP_OKAY;
				case (S_AXI_ARADDR[4:2])
					3'h0: S_AXI_RDATA <= {21'h0, ctrl_r};
					3'h1: S_AXI_RDATA <= {22'h0, cmpa_r};
					3'h2: S_AXI_RDATA <= {22'h0, cmpp_r};
					3'h3: S_AXI_RDATA <= {22'h0, cnt_r};
					3'h4: S_AXI_RDATA <= {30'h0, flag_r};
					default: begin
						S_AXI_RDATA <= 32'h00000000;
						S_AXI_RRESP <= `PTM_RESP_SLVERR;
					end
				endcase
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule

// [core/ptm_defs.vh]
// Offsets, field positions and reset values of the periodic timer block
`ifndef PTM_DEFS_VH
`define PTM_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PTM_OFS_CTRL 5'h00
`define PTM_OFS_CMPA 5'h04
`define PTM_OFS_CMPP 5'h08
`define PTM_OFS_CNT 5'h0C
`define PTM_OFS_FLAG 5'h10

// ****************************************
// Control register fields
// ****************************************
`define PTM_F_RUN 0
`define PTM_F_CKS_LO 1
`define PTM_F_CKS_HI 2
`define PTM_F_MODE_LO 4
`define PTM_F_MODE_HI 5
`define PTM_F_ACT_LO 6
`define PTM_F_ACT_HI 7
`define PTM_F_OLVL 8
`define PTM_F_INV 9
`define PTM_F_CCLR 10
`define PTM_CTRL_W 11
`define PTM_CTRL_RST 11'h000

// ****************************************
// Flag register fields
// ****************************************
`define PTM_F_FLAG_A 0
`define PTM_F_FLAG_P 1

// ****************************************
// Encodings
// ****************************************
`define PTM_MODE_CMP 2'h0
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TMR 2'h3
`define PTM_ACT_NONE 2'h0
`define PTM_ACT_LOW 2'h1
`define PTM_ACT_HIGH 2'h2
`define PTM_ACT_TGL 2'h3
`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2

`endif

// [tb/ptm_top_properties.sv]
// Bus handshake properties of the periodic timer top
module ptm_top_properties (
	// Clock and reset
	input wire CLK,
	input wire RST_N,
	// Write channels
	input wire S_AXI_AWREADY,
	input wire S_AXI_WREADY,
	input wire [1:0] S_AXI_BRESP,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// Read channels
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// Timer pin
	input wire TIMER_PIN_OE_N
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// Properties
	// ********
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
		&& $stable(S_AXI_BRESP)) else $error("write response dropped");
	chk_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response not released");
	chk_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	chk_ar_ready: assert property (S_AXI_ARREADY != S_AXI_RVALID)
		else $error("read ready wrong");
	chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
		&& $stable(S_AXI_RDATA)) else $error("read data dropped");
	chk_r_release: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read data not released");
	chk_rdata_narrow: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:11] == 21'h0)
		else $error("upper read bits set");
	cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP != 2'h0);
	cover property (S_AXI_RVALID && S_AXI_RREADY);
	cover property (TIMER_PIN_OE_N);
endmodule

// [tb/ptm_top_tb_top.sv]
// Self-checking bench for the periodic timer
`include "ptm_defs.vh"
module ptm_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] awaddr = 5'h0;
	logic [4:0] araddr = 5'h0;
	logic [31:0] wdata = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bready = 1'b0;
	logic arv = 1'b0;
	logic rready = 1'b0;
	logic trig = 1'b0;
	wire awrdy, wrdy, bvalid, arrdy, rvalid, pin, pin_oe_n;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	logic [31:0] d, e;
	logic [1:0] resp;
	int fails = 0;
	int samples_checked = 0;
	int n;
	always #25 clk = ~clk;
	ptm_top DUT (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.EXTERNAL_TRIGGER_PIN(trig), .TIMER_PIN_O(pin), .TIMER_PIN_OE_N(pin_oe_n));
	// ********
	// Bus and compare tasks
	// ********
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awrdy) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arrdy) arv <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic hi(input int k, input int w);
		repeat (w) @(posedge clk);
		d = 0;
		repeat (k) begin
			@(posedge clk);
			d = d + pin;
		end
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_regs;
		rd(`PTM_OFS_CTRL);
		cmp("ctrl reset", 0, d);
		wr(`PTM_OFS_CMPA, 32'hFFFFFFFF);
		rd(`PTM_OFS_CMPA);
		cmp("cmpa narrow", 32'h3FF, d);
		rd(5'h14);
		cmp("unmapped rresp", `PTM_RESP_SLVERR, resp);
		wr(5'h18, 32'h1);
		cmp("unmapped bresp", `PTM_RESP_SLVERR, resp);
	endtask
	task automatic t_pwm;
		wr(`PTM_OFS_CMPP, 32'h4);
		wr(`PTM_OFS_CMPA, 32'h1);
		wr(`PTM_OFS_CTRL, 32'h1A1);
		wr(`PTM_OFS_FLAG, 32'h3);
		hi(8, 8);
		cmp("duty quarter", 2, d);
		rd(`PTM_OFS_FLAG);
		cmp("pwm flags", 3, d);
		wr(`PTM_OFS_CTRL, 32'h3A1);
		hi(8, 8);
		cmp("inverted", 6, d);
		wr(`PTM_OFS_CTRL, 32'h161);
		hi(8, 8);
		cmp("forced high", 8, d);
		rd(`PTM_OFS_CNT);
		e = d;
		rd(`PTM_OFS_CNT);
		cmp("count runs", 1, d !== e);
		wr(`PTM_OFS_CMPA, 32'h5);
		wr(`PTM_OFS_CTRL, 32'h1A1);
		hi(8, 8);
		cmp("full duty", 8, d);
		wr(`PTM_OFS_CMPP, 32'h0);
		wr(`PTM_OFS_CMPA, 32'h200);
		wr(`PTM_OFS_CTRL, 32'h5A1);
		hi(2048, 8);
		cmp("period 1024", 1024, d);
	endtask
	task automatic t_tmr;
		wr(`PTM_OFS_CMPA, 32'h2);
		wr(`PTM_OFS_CMPP, 32'h4);
		wr(`PTM_OFS_CTRL, 32'h431);
		wr(`PTM_OFS_FLAG, 32'h3);
		// Counter may start above compare A, so allow one full wrap first
		hi(1, 1100);
		cmp("pin released", 1, pin_oe_n);
		rd(`PTM_OFS_FLAG);
		cmp("timer flags", 1, d);
	endtask
	task automatic t_pulse;
		wr(`PTM_OFS_CTRL, 32'h0);
		wr(`PTM_OFS_CMPA, 32'h3);
		wr(`PTM_OFS_CTRL, 32'h1E0);
		wr(`PTM_OFS_FLAG, 32'h3);
		trig <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pin !== 1'b1 && n < 4);
		cmp("pulse lead", 1, pin);
		do begin
			@(posedge clk);
			n++;
		end while (pin !== 1'b0 && n < 30);
		cmp("pulse trail", 0, pin);
		trig <= 1'b0;
		rd(`PTM_OFS_CTRL);
		cmp("run cleared", 32'h1E0, d);
		rd(`PTM_OFS_FLAG);
		cmp("pulse flag", 1, d[0]);
		rd(`PTM_OFS_CNT);
		cmp("count held", 3, d);
		wr(`PTM_OFS_CMPA, 32'h100);
		wr(`PTM_OFS_CTRL, 32'h1E1);
		hi(4, 0);
		cmp("soft pulse", 4, d);
		wr(`PTM_OFS_CTRL, 32'h1E0);
		hi(4, 0);
		cmp("soft trail", 0, d);
		rd(`PTM_OFS_CNT);
		cmp("period ignored", 1, d > 32'h4);
	endtask
	task automatic t_cmp;
		wr(`PTM_OFS_CMPA, 32'h2);
		wr(`PTM_OFS_CMPP, 32'h4);
		wr(`PTM_OFS_CTRL, 32'hC1);
		hi(16, 1100);
		cmp("toggle count", 8, d);
		wr(`PTM_OFS_FLAG, 32'h3);
		hi(1, 8);
		rd(`PTM_OFS_FLAG);
		cmp("compare flags", 3, d);
		wr(`PTM_OFS_CMPA, 32'h0);
		wr(`PTM_OFS_CMPP, 32'h0);
		wr(`PTM_OFS_FLAG, 32'h3);
		hi(1, 1100);
		rd(`PTM_OFS_FLAG);
		cmp("overflow flags", 2, d);
	endtask
	task automatic close_out;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#(20000 * 50);
		fails++;
		close_out;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_pwm;
		t_tmr;
		t_pulse;
		t_cmp;
		close_out;
	end
endmodule
bind ptm_top ptm_top_properties u_chk (.CLK, .RST_N, .S_AXI_AWREADY, .S_AXI_WREADY,
	.S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .TIMER_PIN_OE_N);
